// ---- hdl/spf_pkg.sv ----
// Package with the word formats, field widths and frame layout of the speech parameter framer.
package spf_pkg;

    // ****************************************************************
    // Word and frame geometry
    // ****************************************************************
    localparam int WORD_W        = 16;
    localparam int SAMPLE_W      = 13;
    localparam int SAMPLE_PAD_W  = WORD_W - SAMPLE_W;
    localparam int NUM_LOG_AREA  = 8;
    localparam int NUM_SUBFRAME  = 4;
    localparam int NUM_PULSE     = 13;
    localparam int SUB_WORDS     = 4 + NUM_PULSE;
    localparam int FRAME_WORDS   = NUM_LOG_AREA + NUM_SUBFRAME * SUB_WORDS;
    localparam int IDX_W         = 7;

    // ****************************************************************
    // Field widths
    // ****************************************************************
    localparam int LAG_W         = 7;
    localparam int GAIN_W        = 2;
    localparam int GRID_W        = 2;
    localparam int AMP_W         = 6;
    localparam int PULSE_W       = 3;
    localparam int LAG_MIN_OK    = 40;
    localparam int LAG_MAX_OK    = 120;

    // ****************************************************************
    // Timing at the 20 MHz clock
    // ****************************************************************
    localparam int CLK_HZ        = 20_000_000;
    localparam int SAMPLE_HZ     = 8_000;
    localparam int FRAME_MS      = 20;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int FRAME_SAMPLES = SAMPLE_HZ * FRAME_MS / 1000;

    // Sub-frame field positions in transmission order.
    localparam int POS_LAG       = 0;
    localparam int POS_GAIN      = 1;
    localparam int POS_GRID      = 2;
    localparam int POS_AMP       = 3;

    // Width of the field carried in word idx of a coded frame.
    function automatic logic [4:0] field_width(input logic [IDX_W-1:0] idx);
        int s;
        s = 0;
        if (idx < 7'(NUM_LOG_AREA)) begin
            case (idx[2:1])
                2'h0:    field_width = 5'h06;
                2'h1:    field_width = 5'h05;
                2'h2:    field_width = 5'h04;
                default: field_width = 5'h03;
            endcase
        end else begin
            s = (int'(idx) - NUM_LOG_AREA) % SUB_WORDS;
            case (s)
                POS_LAG:  field_width = 5'(LAG_W);
                POS_GAIN: field_width = 5'(GAIN_W);
                POS_GRID: field_width = 5'(GRID_W);
                POS_AMP:  field_width = 5'(AMP_W);
                default:  field_width = 5'(PULSE_W);
            endcase
        end
    endfunction : field_width

    // Keeps only the low width bits of a word.
    function automatic logic [WORD_W-1:0] field_mask(input logic [WORD_W-1:0] w,
                                                     input logic [4:0] width);
        logic [WORD_W-1:0] m;
        m = WORD_W'((17'h00001 << width) - 17'h00001);
        field_mask = w & m;
    endfunction : field_mask

    typedef enum logic [2:0] {
        SPF_IDLE = 3'b001,
        SPF_SEND = 3'b010,
        SPF_LAST = 3'b100
    } spf_state_e;

endpackage : spf_pkg

// ---- hdl/spf_link_if.sv ----
// Interface carrying coded-parameter words and sample words between the two ends.
interface spf_link_if;
    import spf_pkg::*;
    logic              par_valid;   // Parameter word valid.
    logic              par_ready;   // Parameter word accepted.
    logic [WORD_W-1:0] par_data;    // Right-justified parameter word.
    logic              par_first;   // Marks word 0 of a frame.
    logic              smp_valid;   // Sample word valid.
    logic              smp_ready;   // Sample word accepted.
    logic [WORD_W-1:0] smp_data;    // Left-justified sample word.

    modport coder (output par_valid, par_data, par_first, smp_ready,
                   input  par_ready, smp_valid, smp_data);
    modport codec (input  par_valid, par_data, par_first, smp_ready,
                   output par_ready, smp_valid, smp_data);
endinterface : spf_link_if

// ---- hdl/spf_coder_end.sv ----
// Coder end: hands link samples to the encoder, frames coded parameters through a two-entry buffer.
//
// Overview of operation
// R1: Input samples are 13 bits, left-justified.
// R2: Output samples are left-justified, low three bits zero.
// R3: Log-area codes one-two 6 bits, three-four 5.
// R4: Log-area codes five-six 4 bits, seven-eight 3.
// R5: Thirteen 3-bit pulse index codes per sub-frame.
// R6: Lag 7, gain 2, grid 2, amplitude 6 bits.
// R7: Log-area codes first, then sub-frames one to four.
// R8: Decoder accepts every lag code 0 to 127.
// R9: Decoder accepts every code of every field.
// R10: Each parameter is its own right-justified word.
// R11: A frame is 76 words per 20 ms.
// R12: Samples arrive in real time at 8 kHz.
// R13: Zero-fill above field; strobe first frame word.
//
// Design notes
// The encoder datapath hands over one raw code at a time on par_code.
// The position of the code within the frame is kept here, in the word
// counter, so the encoder never states which field it is offering.
// The counter selects the width of the field, and every bit above that
// width is cleared before the word enters the buffer.
// The counter restarts at zero after the last word of a frame, and the
// word taken at position zero carries the frame strobe along with it.
// The strobe is stored beside its word, so a stall on the link cannot
// separate a word from its strobe.
// The two-entry buffer lets the encoder offer a code in every cycle
// while the link is busy; par_ready falls only when both entries hold
// words, so a stall by the far end loses nothing.
// The clock enable also gates par_ready and the sample ready signal.
// Without that gate a word offered while the enable is low would be
// shown as accepted but never stored.
// The encoder must follow the frame layout itself: a code offered out
// of order is still cut to the width of the current position.
// A reset in mid-frame drops any buffered words and restarts the count,
// so the far end sees the next word as a fresh frame start.
// Sample words from the far end pass through a single holding stage.
// The stage frees itself in the cycle in which the encoder takes the
// sample, so one sample per cycle can flow when both sides are ready.
// Only the top 13 bits of a sample word are kept; the three padding bits
// at the bottom are dropped on the way in.
module spf_coder_end
    import spf_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic                 clk,         // 20 MHz clock.
    input  wire logic                 rst_n,       // Asynchronous reset, active low.
    input  wire logic                 ce,          // Clock enable; low freezes all state.
    spf_link_if.coder                 link,        // Link toward the codec end.
    input  wire logic                 par_valid,   // Encoder offers a parameter code.
    output      logic                 par_ready,   // Code accepted this cycle.
    input  wire logic [WORD_W-1:0]    par_code,    // Raw code, upper bits ignored.
    output      logic                 smp_valid,   // Encoder sample word valid.
    input  wire logic                 smp_ready,   // Encoder takes the sample.
    output      logic [SAMPLE_W-1:0]  smp_value,   // 13-bit linear sample.
    output      logic [IDX_W-1:0]     word_index,  // Index of the next code to frame.
    output      logic                 frame_done   // Pulse after word 75 is buffered.
);
    import spf_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The buffer pointers are single bits, so only two entries can be served.
    if (DEPTH != 2) begin : g_bad_depth
        $error("spf_coder_end: DEPTH must be 2");
    end

    // The word counter must be able to reach the last word of a frame.
    if (FRAME_WORDS > (1 << IDX_W)) begin : g_bad_idx
        $error("spf_coder_end: IDX_W too narrow for a frame");
    end

    // A parameter field can never be wider than its container word.
    if (LAG_W > WORD_W || AMP_W > WORD_W) begin : g_bad_field
        $error("spf_coder_end: field wider than a word");
    end

    // The sample must fit in the top bits of its container word.
    if (SAMPLE_W > WORD_W) begin : g_bad_sample
        $error("spf_coder_end: sample wider than a word");
    end

    // ****************************************************************
    // Framing of coded parameters
    // ****************************************************************
    spf_state_e        state;
    spf_state_e        next_state;
    logic [IDX_W-1:0]  idx;
    logic              buf_ready;
    logic              take;
    logic [4:0]        cur_width;
    logic [WORD_W-1:0] packed_word;
    logic              is_last;

    // The width is looked up by position, so order and widths follow the frame layout.
    assign cur_width   = field_width(idx);                       // [R3] [R4] [R5] [R6] [R7]
    assign packed_word = field_mask(par_code, cur_width);        // [R10] [R13]
    assign take        = par_valid && par_ready;
    assign par_ready   = buf_ready && ce;                        // A frozen block takes nothing.
    assign is_last     = (idx == 7'(FRAME_WORDS - 1));           // [R11]
    assign word_index  = idx;

    // State follows position within the frame.
    always_comb begin
        case (state)
            SPF_IDLE: next_state = take ? SPF_SEND : SPF_IDLE;
            SPF_SEND: next_state = (take && idx == 7'(FRAME_WORDS - 2)) ? SPF_LAST : SPF_SEND;
            SPF_LAST: next_state = take ? SPF_IDLE : SPF_LAST;
            default:  next_state = SPF_IDLE;
        endcase
    end

    // Word counter wraps after the last word of a frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx        <= '0;
            state      <= SPF_IDLE;
            frame_done <= 1'b0;
        end else if (ce) begin
            state      <= next_state;
            frame_done <= take && (state == SPF_LAST);           // [R11]
            if (take) begin
                idx <= is_last ? '0 : idx + 7'h01;               // [R11]
            end
        end
    end

    // ****************************************************************
    // Two-entry buffer toward the link
    // ****************************************************************
    logic [WORD_W:0]   mem [DEPTH];
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              push;
    logic              pop;

    assign buf_ready      = (count != 2'h2);
    assign push           = take;
    assign pop            = link.par_valid && link.par_ready;
    assign link.par_valid = (count != 2'h0);
    assign link.par_data  = mem[rd_ptr][WORD_W-1:0];
    assign link.par_first = mem[rd_ptr][WORD_W];                 // [R13]

    // Buffer storage; the first flag rides with its word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (ce && push) begin
            mem[wr_ptr] <= {idx == '0, packed_word};             // [R13]
        end
    end

    // Buffer pointers and fill level; a stall on the link stalls par_ready.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (ce) begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + 2'(push) - 2'(pop);
        end
    end

    // ****************************************************************
    // Sample words from the link toward the encoder
    // ****************************************************************
    logic                smp_full;
    logic [SAMPLE_W-1:0] smp_reg;

    assign link.smp_ready = ce && (!smp_full || smp_ready);      // [R1]
    assign smp_valid      = smp_full;
    assign smp_value      = smp_reg;

    // One-word holding stage; the sample sits in the top 13 bits.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_full <= 1'b0;
            smp_reg  <= '0;
        end else if (ce) begin
            if (link.smp_valid && link.smp_ready) begin
                smp_full <= 1'b1;
                smp_reg  <= link.smp_data[WORD_W-1 -: SAMPLE_W]; // [R1]
            end else if (smp_ready) begin
                smp_full <= 1'b0;
            end
        end
    end

endmodule : spf_coder_end

// ---- hdl/spf_codec_end.sv ----
// Codec end: supplies sample words at the sample rate and accepts coded frames.
module spf_codec_end
    import spf_pkg::*;
(
    input  wire logic                 clk,         // 20 MHz clock.
    input  wire logic                 rst_n,       // Asynchronous reset, active low.
    input  wire logic                 ce,          // Clock enable; low freezes all state.
    spf_link_if.codec                 link,        // Link toward the coder end.
    input  wire logic [SAMPLE_W-1:0]  sample_in,   // Linear sample to send.
    output      logic                 sample_tick, // Pulse when a sample is taken.
    output      logic [IDX_W-1:0]     rx_index,    // Position of last received word.
    output      logic [WORD_W-1:0]    rx_word,     // Last received parameter word.
    output      logic                 rx_strobe,   // Pulse when rx_word is new.
    output      logic                 lag_unusual, // Received lag outside 40..120.
    output      logic                 frame_error  // Frame start not where expected.
);
    import spf_pkg::*;

    // ****************************************************************
    // Sample pacing
    // ****************************************************************
    logic [11:0]       tick_cnt;
    logic              pend;
    logic [WORD_W-1:0] smp_word;

    assign link.smp_valid = pend;
    assign link.smp_data  = smp_word;
    assign sample_tick    = (tick_cnt == 12'(SAMPLE_CYCLES - 1));

    // One sample each 125 us, left-justified with low bits zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            pend     <= 1'b0;
            smp_word <= '0;
        end else if (ce) begin
            tick_cnt <= sample_tick ? '0 : tick_cnt + 12'h001;      // [R12]
            if (sample_tick) begin
                pend     <= 1'b1;
                smp_word <= {sample_in, SAMPLE_PAD_W'(0)};          // [R1] [R2]
            end else if (link.smp_ready) begin
                pend <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Parameter reception
    // ****************************************************************
    logic [IDX_W-1:0] exp_idx;
    logic             got;
    logic             is_lag;
    logic [4:0]       sub_pos;
    logic [IDX_W-1:0] rx_pos;

    // A frame strobe places the word at position zero whatever the count says.
    assign link.par_ready = ce;                                     // [R9]
    assign got            = link.par_valid && ce;
    assign rx_pos         = link.par_first ? '0 : exp_idx;          // [R7]
    assign sub_pos        = 5'((int'(rx_pos) - NUM_LOG_AREA) % SUB_WORDS);
    assign is_lag         = (rx_pos >= 7'(NUM_LOG_AREA)) && (sub_pos == 5'(POS_LAG));

    // Every code is taken; an odd lag only raises a status flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_idx     <= '0;
            rx_index    <= '0;
            rx_word     <= '0;
            rx_strobe   <= 1'b0;
            lag_unusual <= 1'b0;
            frame_error <= 1'b0;
        end else if (ce) begin
            rx_strobe <= got;
            if (got) begin
                rx_word     <= field_mask(link.par_data, field_width(rx_pos)); // [R9] [R10]
                rx_index    <= rx_pos;
                exp_idx     <= link.par_first ? 7'h01 :
                               (exp_idx == 7'(FRAME_WORDS - 1)) ? '0 : exp_idx + 7'h01; // [R11]
                frame_error <= link.par_first != (exp_idx == '0);
                if (is_lag) begin
                    lag_unusual <= (link.par_data[LAG_W-1:0] < 7'(LAG_MIN_OK)) ||
                                   (link.par_data[LAG_W-1:0] > 7'(LAG_MAX_OK)); // [R8]
                end
            end
        end
    end

endmodule : spf_codec_end

// ---- tb/spf_tb_pkg.sv ----
// Package with the bench's own table of field widths per word position.
package spf_tb_pkg;

    // Width of the field in word k of a coded frame.
    function automatic int exp_width(input int k);
        if (k < 8) begin
            return 6 - k / 2;
        end
        case ((k - 8) % 17)
            0:       return 7;
            1, 2:    return 2;
            3:       return 6;
            default: return 3;
        endcase
    endfunction : exp_width

endpackage : spf_tb_pkg

// ---- tb/spf_link_properties.sv ----
// Checker of the parameter and sample handshakes on the link between the two ends.
module spf_link_properties
    import spf_pkg::*;
(
    input wire logic              clk,        // Clock.
    input wire logic              rst_n,      // Reset, active low.
    input wire logic              par_valid,  // Parameter word valid.
    input wire logic              par_ready,  // Parameter word accepted.
    input wire logic [WORD_W-1:0] par_data,   // Parameter word.
    input wire logic              par_first,  // First word strobe.
    input wire logic              smp_valid,  // Sample word valid.
    input wire logic              smp_ready,  // Sample word accepted.
    input wire logic [WORD_W-1:0] smp_data    // Sample word.
);
    timeunit 1ns;
    timeprecision 1ps;
    import spf_tb_pkg::*;

    logic [6:0]  pos;   // Frame position of the word on the link.
    logic [11:0] gap;   // Cycles since the last sample handshake.
    wire         take = par_valid && par_ready;
    wire [15:0]  mask = 16'((17'h00001 << exp_width(int'(pos))) - 17'h00001);

    // Tracks the frame position and the spacing of sample words.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 7'h00;
            gap <= 12'h000;
        end else begin
            if (take) begin
                pos <= (pos == 7'h4B) ? 7'h00 : pos + 7'h01;
            end
            gap <= (smp_valid && smp_ready) ? 12'h000 : ((gap == 12'hFFF) ? gap : gap + 12'h001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_PAR_ZERO_FILL: assert property (par_valid |-> (par_data & ~mask) == 16'h0000)
        else $error("parameter word has bits above its field");
    AST_FIRST_AT_ZERO: assert property (par_valid && pos == 7'h00 |-> par_first)
        else $error("first word of a frame lacks its strobe");
    AST_FIRST_ONLY_ZERO: assert property (par_valid && pos != 7'h00 |-> !par_first)
        else $error("frame strobe on a word other than the first");
    AST_IDX_WRAP: assert property (take && pos == 7'h4B |=> !par_valid || par_first)
        else $error("word after the last of a frame is not a frame start");
    AST_ALL_ACCEPTED: assert property (par_valid |-> par_ready)
        else $error("codec end refused a parameter word");
    AST_SMP_PAD: assert property (smp_valid |-> smp_data[2:0] == 3'h0)
        else $error("sample word low bits not zero");
    AST_SMP_HOLD: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
        else $error("sample word dropped before it was taken");
    AST_SMP_RATE: assert property (smp_valid && smp_ready |-> gap >= 12'd2490)
        else $error("sample words closer than the sample period");

    COV_FRAME_END: cover property (take && pos == 7'h4B);
    COV_FIRST: cover property (take && par_first);
    COV_SAMPLE: cover property (smp_valid && smp_ready);
endmodule : spf_link_properties

// ---- tb/tb.sv ----
// Testbench joining the coder end and the codec end across the link interface.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spf_pkg::*;
    import spf_tb_pkg::*;

    logic clk, rst_n, par_valid, smp_ready, par_ready, smp_valid, frame_done;
    logic sample_tick, rx_strobe, lag_unusual, frame_error;
    logic [15:0] par_code, rx_word, code_row [76], exp_row [76];
    logic [12:0] sample_in, smp_value;
    logic [6:0]  word_index, rx_index;
    int err_count, cmp_count, cyc, rx_n, rx_total, fd_n, t1, n, f, k, tk_n;

    spf_link_if link ();
    spf_coder_end #(.DEPTH(2)) i_spf_coder_end (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .link(link), .par_valid(par_valid), .par_ready(par_ready), .par_code(par_code),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_value(smp_value),
        .word_index(word_index), .frame_done(frame_done));
    spf_codec_end i_spf_codec_end (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link),
        .sample_in(sample_in), .sample_tick(sample_tick), .rx_index(rx_index),
        .rx_word(rx_word), .rx_strobe(rx_strobe), .lag_unusual(lag_unusual),
        .frame_error(frame_error));
    spf_link_properties i_spf_link_properties (.clk(clk), .rst_n(rst_n),
        .par_valid(link.par_valid), .par_ready(link.par_ready), .par_data(link.par_data),
        .par_first(link.par_first), .smp_valid(link.smp_valid), .smp_ready(link.smp_ready),
        .smp_data(link.smp_data));

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Offers one code and holds it until the edge at which it is taken.
    task automatic send(input logic [15:0] c);
        logic r;
        int m;
        par_valid <= 1'b1;
        par_code <= c;
        m = 0;
        do begin
            @(negedge clk);
            r = par_ready;
            @(posedge clk);
            m++;
        end while (r !== 1'b1 && m < 50);
    endtask : send

    always #25 clk = ~clk;

    // Cuts a hang short after a cycle ceiling.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    // Checks every received word against the row of its position.
    always @(negedge clk) begin
        if (!rst_n) begin
            rx_n = 0;
        end else begin
            fd_n += (frame_done === 1'b1);
            tk_n += (sample_tick === 1'b1);
            if (rx_strobe === 1'b1) begin
                check("rx_word", exp_row[rx_n], rx_word);
                check("rx_index", 16'(rx_n), 16'(rx_index));
                check("frame_error", 16'h0000, 16'(frame_error));
                if (rx_n >= 8 && (rx_n - 8) % 17 == 0) begin
                    check("lag_unusual", 16'(exp_row[rx_n] < 40 || exp_row[rx_n] > 120), 16'(lag_unusual));
                end
                rx_n = (rx_n == 75) ? 0 : rx_n + 1;
                rx_total++;
            end
        end
    end

    initial begin
        clk = 0;
        rst_n = 0;
        par_valid = 0;
        par_code = 16'h0000;
        smp_ready = 0;
        sample_in = 13'h1ABC;
        for (k = 0; k < 76; k++) begin
            code_row[k] = (k % 2) ? 16'hFFFF : 16'hA5A5;
            if (k >= 8 && (k - 8) % 17 == 0) begin
                code_row[k] = (k < 25) ? 16'hFF80 : ((k < 42) ? 16'h007F : ((k < 59) ? 16'h0028 : 16'h0078));
            end
            exp_row[k] = code_row[k] & 16'((17'h00001 << exp_width(k)) - 17'h00001);
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (f = 0; f < 2; f++) begin
            for (k = 0; k < 76; k++) begin
                send(code_row[k]);
            end
        end
        par_valid <= 1'b0;
        repeat (4) @(negedge clk);
        check("rx_total", 16'd152, 16'(rx_total));
        check("frame_done", 16'd2, 16'(fd_n));
        check("word_index", 16'h0000, 16'(word_index));
        $display("test frames done");
        n = 0;
        while (smp_valid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        t1 = cyc;
        repeat (5) @(negedge clk);
        check("smp_held", 16'h0001, 16'(smp_valid));
        check("smp_value", 16'h1ABC, 16'(smp_value));
        @(posedge clk);
        smp_ready <= 1'b1;
        sample_in <= 13'h0001;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (smp_valid !== 1'b0 && n < 10);
        n = 0;
        while (smp_valid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check("smp_value", 16'h0001, 16'(smp_value));
        check("smp_period", 16'd2500, 16'(cyc - t1));
        check("sample_tick", 16'd2, 16'(tk_n));
        $display("test samples done");
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check("rst_par_ready", 16'h0001, 16'(par_ready));
        check("rst_smp_valid", 16'h0000, 16'(smp_valid));
        check("rst_word_index", 16'h0000, 16'(word_index));
        @(posedge clk);
        rst_n <= 1'b1;
        rx_total = 0;
        send(code_row[0]);
        par_valid <= 1'b0;
        repeat (3) @(negedge clk);
        check("rx_after_reset", 16'd1, 16'(rx_total));
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : tb
